/* File: tcc_pkg.sv */
// Constants, register map and helpers for the timer capture and compare block
package tcc_pkg;

  // Register byte offsets
  localparam logic [5:0] TCC_OFF_CTRL_A = 6'h00;
  localparam logic [5:0] TCC_OFF_CTRL_B = 6'h04;
  localparam logic [5:0] TCC_OFF_CTRL_C = 6'h08;
  localparam logic [5:0] TCC_OFF_CNT_L  = 6'h0C;
  localparam logic [5:0] TCC_OFF_CNT_H  = 6'h10;
  localparam logic [5:0] TCC_OFF_CAP_L  = 6'h14;
  localparam logic [5:0] TCC_OFF_CAP_H  = 6'h18;
  localparam logic [1:0][5:0] TCC_OFF_CMP_L = {6'h24, 6'h1C};
  localparam logic [1:0][5:0] TCC_OFF_CMP_H = {6'h28, 6'h20};
  localparam logic [5:0] TCC_OFF_IRQ_EN = 6'h2C;
  localparam logic [5:0] TCC_OFF_FLAGS  = 6'h30;

  // Field positions
  localparam int TCC_B_COM_A   = 6;
  localparam int TCC_B_COM_B   = 4;
  localparam int TCC_B_FILT    = 7;
  localparam int TCC_B_EDGE    = 6;
  localparam int TCC_B_SRC     = 5;
  localparam int TCC_B_WGM_HI  = 3;
  localparam int TCC_B_FORCE_A = 7;
  localparam int TCC_B_CAP_F   = 5;
  localparam int TCC_B_CMP_F   = 1;

  // Clock select codes
  localparam logic [2:0] TCC_CS_STOP  = 3'h0;
  localparam logic [2:0] TCC_CS_DIV1  = 3'h1;
  localparam logic [2:0] TCC_CS_DIV8  = 3'h2;
  localparam logic [2:0] TCC_CS_DIV64 = 3'h3;
  localparam logic [2:0] TCC_CS_D256  = 3'h4;
  localparam logic [2:0] TCC_CS_D1024 = 3'h5;
  localparam logic [2:0] TCC_CS_EXTF  = 3'h6;

  localparam int         TCC_FILT_LEN = 4;
  localparam logic [15:0] TCC_MAX     = 16'hFFFF;
  localparam logic [7:0]  TCC_RST     = 8'h00;

  // Waveform mode classes
  function automatic logic tcc_is_pwm(input logic [3:0] m);
    return !(m == 4'h0 || m == 4'h4 || m == 4'hC || m == 4'hD);
  endfunction

  function automatic logic tcc_is_dual(input logic [3:0] m);
    return (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hB);
  endfunction

  function automatic logic tcc_cap_top(input logic [3:0] m);
    return m == 4'h8 || m == 4'hA || m == 4'hC || m == 4'hE;
  endfunction

  function automatic logic tcc_upd_bot(input logic [3:0] m);
    return m == 4'h8 || m == 4'h9;
  endfunction

  function automatic logic [15:0] tcc_top_val(input logic [3:0] m,
                                              input logic [15:0] cmpa,
                                              input logic [15:0] cap);
    logic [15:0] t;
    t = TCC_MAX;
    unique case (m)
      4'h1, 4'h5: t = 16'h00FF;
      4'h2, 4'h6: t = 16'h01FF;
      4'h3, 4'h7: t = 16'h03FF;
      4'h4, 4'h9, 4'hB, 4'hF: t = cmpa;
      4'h8, 4'hA, 4'hC, 4'hE: t = cap;
      default: t = TCC_MAX;
    endcase
    return t;
  endfunction

endpackage

/* File: tcc_top.sv */
// Timer capture front end and two compare units behind an Avalon-MM slave
// Notes on behaviour
// - Changing capture source may capture; software clears the flag afterwards.
// - Enabled filter adds four system clocks before the edge detector.
// - Filter and detector always active; capture blocked while capture value sets TOP.
// - A software-driven edge on the capture pin captures like any edge.
// - Filter output changes only after four equal samples; detector uses it.
// - Filter enable bit in control B; clear means bypass.
// - Filter runs on the system clock, independent of prescaler.
// - Every capture overwrites the capture value, read or not.
// - Counter equal to compare value sets flag at timer tick.
// - Flag plus enable requests interrupt; cleared by service or writing one.
// - Compare A may set the counter TOP.
// - Compare value double buffered in the twelve PWM modes only.
// - Buffer moves to active compare value at TOP or BOTTOM.
// - CPU reaches buffer when buffered, active value otherwise.
// - Compare high byte reads directly, not through temp byte.
// - High byte goes to temp; low write loads both bytes together.
// - Force strobe in non-PWM modes acts on output, no flag, no counter.
// - Counter write blocks all matches at the next timer tick.
// - Writing counter equal to variable TOP skips TOP; counter runs on.
// - Compare output state survives waveform mode changes.
// - Output action bits are unbuffered and act at once.
// - Capture copies counter and sets capture flag in same cycle.
// - Capture low read copies high byte to temp; high read returns temp.
// - CPU counter write beats count or clear in that cycle.
// - Output action zero leaves compare output unchanged on match.
`timescale 1ns/10ps
module tcc_top
  import tcc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Event and count inputs
  input  wire logic        capture_input_a,
  input  wire logic        capture_input_b,
  input  wire logic        external_count_input,
  // Interrupt service acknowledges
  input  wire logic        capture_irq_ack,
  input  wire logic        compare_irq_ack_a,
  input  wire logic        compare_irq_ack_b,
  // Requests and compare outputs
  output logic             capture_irq,
  output logic             compare_irq_a,
  output logic             compare_irq_b,
  output logic             compare_output_a,
  output logic             compare_output_b
);

  typedef struct packed {
    logic             waitreq;
    logic [7:0]       rdata;
    logic [7:0]       temp;
    logic [15:0]      cnt;
    logic             dir_up;
    logic             blk;
    logic [15:0]      cap;
    logic [1:0][15:0] ocr;
    logic [1:0][15:0] obuf;
    logic [1:0]       oc;
    logic [1:0][1:0]  com;
    logic [3:0]       wgm;
    logic [2:0]       cs;
    logic             filt_en;
    logic             edge_sel;
    logic             src_sel;
    logic             cap_ie;
    logic [1:0]       cmp_ie;
    logic             cap_f;
    logic [1:0]       cmp_f;
    logic             cap_irq;
    logic [1:0]       cmp_irq;
    logic [9:0]       pre;
    logic [2:0]       ext_s;
    logic [1:0]       cap_s;
    logic [3:0]       fsh;
    logic             fout;
    logic             det_prev;
  } tcc_state_s;

  tcc_state_s s_r;
  tcc_state_s s_nxt;

  logic        wr_go;
  logic        rd_go;
  logic [7:0]  wd;
  logic [15:0] top;
  logic        pwm;
  logic        dual;
  logic        tick;
  logic        filt_val;
  logic        det_in;
  logic        edge_hit;
  logic        at_top;
  logic        at_bot;
  logic [1:0]  ack;

  // Output action on a compare match
  function automatic logic match_act(input logic [1:0] com, input logic oc,
                                     input logic p, input logic d,
                                     input logic up);
    logic r;
    r = oc;
    if (!p)
    begin
      unique case (com)
        2'h1: r = ~oc;
        2'h2: r = 1'b0;
        2'h3: r = 1'b1;
        default: r = oc;
      endcase
    end
    else if (d)
    begin
      if (com == 2'h2)
        r = !up;
      else if (com == 2'h3)
        r = up;
    end
    else
    begin
      if (com == 2'h2)
        r = 1'b1;
      else if (com == 2'h3)
        r = 1'b0;
    end
    return r;
  endfunction

  always_comb
  begin
    s_nxt    = s_r;
    wr_go    = avs_write && !s_r.waitreq && avs_byteenable[0];
    rd_go    = avs_read && s_r.waitreq;
    wd       = avs_writedata[7:0];
    top      = tcc_top_val(s_r.wgm, s_r.ocr[0], s_r.cap);
    pwm      = tcc_is_pwm(s_r.wgm);
    dual     = tcc_is_dual(s_r.wgm);
    ack      = {compare_irq_ack_b, compare_irq_ack_a};
    at_top   = (s_r.cnt == top) && !s_r.blk;
    at_bot   = s_r.cnt == 16'h0000;

    // Bus handshake: one wait cycle per request
    s_nxt.waitreq = !((avs_read || avs_write) && s_r.waitreq);

    // Flag clears first so a same-cycle event wins
    // Service or write-one clear
    if (capture_irq_ack)
      s_nxt.cap_f = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      if (ack[i])
        s_nxt.cmp_f[i] = 1'b0;
    end
    if (wr_go && avs_address == TCC_OFF_FLAGS)
    begin
      if (wd[TCC_B_CAP_F])
        s_nxt.cap_f = 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        if (wd[TCC_B_CMP_F + i])
          s_nxt.cmp_f[i] = 1'b0;
      end
    end

    // Timer clock from prescaler or external input
    s_nxt.pre   = s_r.pre + 10'h001;
    s_nxt.ext_s = {s_r.ext_s[1:0], external_count_input};
    unique case (s_r.cs)
      TCC_CS_STOP:  tick = 1'b0;
      TCC_CS_DIV1:  tick = 1'b1;
      TCC_CS_DIV8:  tick = &s_r.pre[2:0];
      TCC_CS_DIV64: tick = &s_r.pre[5:0];
      TCC_CS_D256:  tick = &s_r.pre[7:0];
      TCC_CS_D1024: tick = &s_r.pre;
      TCC_CS_EXTF:  tick = !s_r.ext_s[1] && s_r.ext_s[2];
      default:      tick = s_r.ext_s[1] && !s_r.ext_s[2];
    endcase

    s_nxt.cap_s = {s_r.cap_s[0], s_r.src_sel ? capture_input_b : capture_input_a};

    s_nxt.fsh = {s_r.fsh[2:0], s_r.cap_s[1]};
    filt_val  = (&s_r.fsh || ~|s_r.fsh) ? s_r.fsh[TCC_FILT_LEN-1] : s_r.fout;
    s_nxt.fout = filt_val;
    det_in         = s_r.filt_en ? filt_val : s_r.cap_s[1];
    s_nxt.det_prev = det_in;
    edge_hit = s_r.edge_sel ? (det_in && !s_r.det_prev) : (!det_in && s_r.det_prev);

    if (edge_hit && !tcc_cap_top(s_r.wgm))
    begin
      s_nxt.cap   = s_r.cnt;
      s_nxt.cap_f = 1'b1;
    end

    if (tick)
    begin
      s_nxt.blk = 1'b0;
      if (dual)
      begin
        if (s_r.dir_up)
        begin
          if (at_top)
          begin
            s_nxt.dir_up = 1'b0;
            s_nxt.cnt    = s_r.cnt - 16'h0001;
          end
          else
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
        else if (at_bot)
        begin
          s_nxt.dir_up = 1'b1;
          s_nxt.cnt    = s_r.cnt + 16'h0001;
        end
        else
          s_nxt.cnt = s_r.cnt - 16'h0001;
      end
      else
        s_nxt.cnt = at_top ? 16'h0000 : s_r.cnt + 16'h0001;

      for (int i = 0; i < 2; i++)
      begin
        if (s_r.cnt == s_r.ocr[i] && !s_r.blk)
        begin
          s_nxt.cmp_f[i] = 1'b1;
          s_nxt.oc[i] = match_act(s_r.com[i], s_r.oc[i], pwm, dual, s_r.dir_up);
        end
        if (pwm && !dual && at_top)
        begin
          if (s_r.com[i] == 2'h2)
            s_nxt.oc[i] = 1'b0;
          else if (s_r.com[i] == 2'h3)
            s_nxt.oc[i] = 1'b1;
        end
        // Buffer update at TOP or BOTTOM
        if (pwm && (tcc_upd_bot(s_r.wgm) ? at_bot : at_top))
          s_nxt.ocr[i] = s_r.obuf[i];
      end
    end

    // Register writes
    if (wr_go)
    begin
      unique case (avs_address)
        TCC_OFF_CTRL_A:
        begin
          // Output state untouched by mode change
          s_nxt.com[0]   = wd[TCC_B_COM_A +: 2];
          s_nxt.com[1]   = wd[TCC_B_COM_B +: 2];
          s_nxt.wgm[1:0] = wd[1:0];
        end
        TCC_OFF_CTRL_B:
        begin
          s_nxt.filt_en  = wd[TCC_B_FILT];
          s_nxt.edge_sel = wd[TCC_B_EDGE];
          s_nxt.src_sel  = wd[TCC_B_SRC];
          s_nxt.wgm[3:2] = wd[TCC_B_WGM_HI +: 2];
          s_nxt.cs       = wd[2:0];
        end
        TCC_OFF_CTRL_C:
        begin
          for (int i = 0; i < 2; i++)
          begin
            if (wd[TCC_B_FORCE_A - i] && !pwm)
              s_nxt.oc[i] = match_act(s_r.com[i], s_r.oc[i], 1'b0, 1'b0, 1'b1);
          end
        end
        TCC_OFF_CNT_L:
        begin
          s_nxt.cnt = {s_r.temp, wd};
          s_nxt.blk = 1'b1;
        end
        TCC_OFF_CAP_L:
        begin
          if (tcc_cap_top(s_r.wgm))
            s_nxt.cap = {s_r.temp, wd};
        end
        TCC_OFF_CNT_H, TCC_OFF_CAP_H, TCC_OFF_CMP_H[0], TCC_OFF_CMP_H[1]:
        begin
          s_nxt.temp = wd;
        end
        TCC_OFF_IRQ_EN:
        begin
          s_nxt.cap_ie = wd[TCC_B_CAP_F];
          s_nxt.cmp_ie = wd[TCC_B_CMP_F +: 2];
        end
        default:
        begin
          for (int i = 0; i < 2; i++)
          begin
            if (avs_address == TCC_OFF_CMP_L[i])
            begin
              if (pwm)
                s_nxt.obuf[i] = {s_r.temp, wd};
              else
                s_nxt.ocr[i] = {s_r.temp, wd};
            end
          end
        end
      endcase
    end

    // Register reads, captured on the first request cycle
    if (rd_go)
    begin
      s_nxt.rdata = TCC_RST;
      unique case (avs_address)
        TCC_OFF_CTRL_A:
          s_nxt.rdata = {s_r.com[0], s_r.com[1], 2'h0, s_r.wgm[1:0]};
        TCC_OFF_CTRL_B:
          s_nxt.rdata = {s_r.filt_en, s_r.edge_sel, s_r.src_sel, s_r.wgm[3:2], s_r.cs};
        TCC_OFF_CNT_L:
        begin
          s_nxt.rdata = s_r.cnt[7:0];
          s_nxt.temp  = s_r.cnt[15:8];
        end
        TCC_OFF_CAP_L:
        begin
          s_nxt.rdata = s_r.cap[7:0];
          s_nxt.temp  = s_r.cap[15:8];
        end
        TCC_OFF_CNT_H, TCC_OFF_CAP_H:
          s_nxt.rdata = s_r.temp;
        TCC_OFF_IRQ_EN:
          s_nxt.rdata = {2'h0, s_r.cap_ie, 2'h0, s_r.cmp_ie, 1'b0};
        TCC_OFF_FLAGS:
          s_nxt.rdata = {2'h0, s_r.cap_f, 2'h0, s_r.cmp_f, 1'b0};
        default:
        begin
          for (int i = 0; i < 2; i++)
          begin
            if (avs_address == TCC_OFF_CMP_L[i])
              s_nxt.rdata = pwm ? s_r.obuf[i][7:0] : s_r.ocr[i][7:0];
            if (avs_address == TCC_OFF_CMP_H[i])
              s_nxt.rdata = pwm ? s_r.obuf[i][15:8] : s_r.ocr[i][15:8];
          end
        end
      endcase
    end

    // Request when flag and enable set
    s_nxt.cap_irq = s_nxt.cap_f && s_nxt.cap_ie;
    s_nxt.cmp_irq = s_nxt.cmp_f & s_nxt.cmp_ie;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r         <= '0;
      s_r.waitreq <= 1'b1;
      s_r.dir_up  <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign avs_readdata     = {24'h000000, s_r.rdata};
  assign avs_waitrequest  = s_r.waitreq;
  assign capture_irq      = s_r.cap_irq;
  assign compare_irq_a    = s_r.cmp_irq[0];
  assign compare_irq_b    = s_r.cmp_irq[1];
  assign compare_output_a = s_r.oc[0];
  assign compare_output_b = s_r.oc[1];

endmodule

/* File: tcc_evt_src.sv */
// Event source model driving the two capture pins
`timescale 1ns/10ps
module tcc_evt_src (
  // Clock
  input  wire logic clk,
  input  wire logic rst_n,
  // Levels asked for by software
  input  wire logic lvl_a,
  input  wire logic lvl_b,
  // Pins
  output logic      capture_input_a,
  output logic      capture_input_b
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      capture_input_a <= 1'b0;
      capture_input_b <= 1'b0;
    end
    else
    begin
      capture_input_a <= lvl_a;
      capture_input_b <= lvl_b;
    end
  end
endmodule

/* File: tcc_top_sva.sv */
// Assertion checker for the timer capture and compare block
`timescale 1ns/10ps
module tcc_top_sva
  import tcc_pkg::*;
(
  // Clock
  input wire logic        clk,
  input wire logic        rst_n,
  // Bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins
  input wire logic        capture_input_a,
  input wire logic        capture_input_b,
  input wire logic        external_count_input,
  input wire logic        capture_irq_ack,
  input wire logic        compare_irq_ack_a,
  input wire logic        compare_irq_ack_b,
  // Outputs
  input wire logic        capture_irq,
  input wire logic        compare_irq_a,
  input wire logic        compare_irq_b,
  input wire logic        compare_output_a,
  input wire logic        compare_output_b
);
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] irq_en_r;
  logic [4:0] quiet_r;
  logic [1:0] pin_r;
  logic       wr_ok;
  logic       wr_force;
  logic       stopped;
  logic [3:0] mode;
  assign wr_ok    = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wr_force = wr_ok && avs_address == TCC_OFF_CTRL_C && avs_writedata[TCC_B_FORCE_A];
  assign mode     = {ctrl_b_r[4:3], ctrl_a_r[1:0]};
  assign stopped  = ctrl_b_r[2:0] == TCC_CS_STOP && !tcc_is_pwm(mode);
  // Shadow of the control bits and a quiet counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_a_r <= TCC_RST;
      ctrl_b_r <= TCC_RST;
      irq_en_r <= TCC_RST;
      quiet_r  <= 5'h00;
      pin_r    <= 2'h0;
    end
    else
    begin
      pin_r <= {capture_input_b, capture_input_a};
      if (wr_ok && avs_address == TCC_OFF_CTRL_A)
        ctrl_a_r <= avs_writedata[7:0];
      if (wr_ok && avs_address == TCC_OFF_CTRL_B)
        ctrl_b_r <= avs_writedata[7:0];
      if (wr_ok && avs_address == TCC_OFF_IRQ_EN)
        irq_en_r <= avs_writedata[7:0];
      if (wr_ok || pin_r != {capture_input_b, capture_input_a})
        quiet_r <= 5'h00;
      else if (quiet_r != 5'h1F)
        quiet_r <= quiet_r + 5'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  a_rd_upper: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  a_cap_cause: assert property ($rose(capture_irq) |-> quiet_r < 5'h10)
    else $error("capture request with no recent pin edge or write");
  a_cap_mask: assert property (!irq_en_r[TCC_B_CAP_F] [*3] |-> !capture_irq)
    else $error("capture request while disabled");
  a_cmp_mask: assert property (!irq_en_r[TCC_B_CMP_F] [*3] |-> !compare_irq_a)
    else $error("compare request while disabled");
  a_ack_clear: assert property (capture_irq_ack && quiet_r == 5'h1F |-> ##[1:3] !capture_irq)
    else $error("service pulse did not clear capture request");
  a_force_flag: assert property (wr_force && stopped && !compare_irq_a |=> !compare_irq_a [*3])
    else $error("forced match raised the compare request");
  a_force_toggle: assert property (wr_force && stopped && ctrl_a_r[7:6] == 2'h1
    |=> compare_output_a != $past(compare_output_a))
    else $error("forced toggle did not change output");
  a_force_none: assert property (wr_force && stopped && ctrl_a_r[7:6] == 2'h0
    |=> $stable(compare_output_a))
    else $error("forced match with no action changed output");
  c_capture: cover property ($rose(capture_irq));
  c_compare: cover property ($rose(compare_irq_a));
  c_force: cover property (wr_force && stopped && ctrl_a_r[7:6] == 2'h1);
endmodule
bind tcc_top tcc_top_sva chk_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .capture_input_a(capture_input_a),
  .capture_input_b(capture_input_b), .external_count_input(external_count_input),
  .capture_irq_ack(capture_irq_ack), .compare_irq_ack_a(compare_irq_ack_a),
  .compare_irq_ack_b(compare_irq_ack_b), .capture_irq(capture_irq),
  .compare_irq_a(compare_irq_a), .compare_irq_b(compare_irq_b),
  .compare_output_a(compare_output_a), .compare_output_b(compare_output_b));

/* File: tcc_top_bench.sv */
// Self-checking bench for the timer capture and compare block
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tcc_top_bench;
  import tcc_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        cap_a;
  logic        cap_b;
  logic        lvl_a;
  logic        lvl_b;
  logic        cap_ack;
  logic        ack_a;
  logic        capture_irq;
  logic        compare_irq_a;
  logic        compare_irq_b;
  logic        compare_output_a;
  logic        compare_output_b;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n_plain;
  int          n_filt;
  int          n;
  logic [7:0]  exp_q[$];
  logic [7:0]  e_r;
  logic [15:0] seed = 16'h0050;
  logic [15:0] v;
  logic [15:0] cv;
  logic [15:0] cv2;
  logic [15:0] cmpv0;
  logic [5:0]  addr_t[8] = '{TCC_OFF_CTRL_A, TCC_OFF_CTRL_B, TCC_OFF_CTRL_C, TCC_OFF_CNT_L,
                             TCC_OFF_CAP_L, TCC_OFF_CMP_H[1], TCC_OFF_FLAGS, 6'h34};
  logic [1:0]  act_t[5] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h3};
  logic        out_t[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  tcc_top dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .capture_input_a(cap_a),
    .capture_input_b(cap_b), .external_count_input(1'b0), .capture_irq_ack(cap_ack),
    .compare_irq_ack_a(ack_a), .compare_irq_ack_b(1'b0), .capture_irq(capture_irq),
    .compare_irq_a(compare_irq_a), .compare_irq_b(compare_irq_b),
    .compare_output_a(compare_output_a), .compare_output_b(compare_output_b));
  tcc_evt_src evt_u (.clk(clk), .rst_n(rst_n), .lvl_a(lvl_a), .lvl_b(lvl_b),
    .capture_input_a(cap_a), .capture_input_b(cap_b));
  function automatic logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {24'h000000, d};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wait_irq(input logic k, output int c);
    c = 0;
    while ((k ? compare_irq_a : capture_irq) !== 1'b1 && c < 40)
    begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      e_r = exp_q.pop_front();
      `CHK(avs_readdata[7:0], e_r)
    end
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end
  initial
  begin
    {rst_n, avs_address, avs_read, avs_write, avs_writedata} = '0;
    {lvl_a, lvl_b, cap_ack, ack_a} = '0;
    avs_byteenable = 4'hF;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (addr_t[i]) rd(addr_t[i], TCC_RST);
    $display("test reset done");
    for (int i = 0; i < 2; i++)
    begin
      v = rnd();
      wr(TCC_OFF_CMP_H[i], v[15:8]);
      rd(TCC_OFF_CMP_H[i], 8'h00);
      wr(TCC_OFF_CMP_L[i], v[7:0]);
      rd(TCC_OFF_CMP_H[i], v[15:8]);
      rd(TCC_OFF_CMP_L[i], v[7:0]);
      cmpv0 = (i == 0) ? v : cmpv0;
    end
    avs_byteenable <= 4'hE;
    wr(TCC_OFF_CMP_L[0], ~cmpv0[7:0]);
    avs_byteenable <= 4'hF;
    rd(TCC_OFF_CMP_L[0], cmpv0[7:0]);
    $display("test compare access done");
    wr(TCC_OFF_IRQ_EN, 8'h01 << TCC_B_CAP_F);
    wr(TCC_OFF_CTRL_B, 8'h01 << TCC_B_EDGE);
    wr(TCC_OFF_FLAGS, 8'hFF);
    cv = rnd();
    wr(TCC_OFF_CNT_H, cv[15:8]);
    wr(TCC_OFF_CNT_L, cv[7:0]);
    lvl_a <= 1'b1;
    wait_irq(1'b0, n_plain);
    `CHK(capture_irq, 1'b1)
    rd(TCC_OFF_CAP_L, cv[7:0]);
    v = rnd();
    cv2 = {~cv[15:8], v[7:0]};
    wr(TCC_OFF_CNT_H, cv2[15:8]);
    wr(TCC_OFF_CNT_L, cv2[7:0]);
    repeat (40) @(posedge clk);
    cap_ack <= 1'b1;
    @(posedge clk);
    cap_ack <= 1'b0;
    lvl_a   <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK(capture_irq, 1'b0)
    lvl_a <= 1'b1;
    wait_irq(1'b0, n);
    rd(TCC_OFF_CAP_H, cv2[15:8]);
    rd(TCC_OFF_CAP_L, cv2[7:0]);
    rd(TCC_OFF_CAP_H, cv2[15:8]);
    wr(TCC_OFF_CTRL_B, 8'h00);
    wr(TCC_OFF_FLAGS, 8'hFF);
    lvl_b <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(capture_irq, 1'b0)
    wr(TCC_OFF_CTRL_B, 8'h01 << TCC_B_SRC);
    repeat (10) @(posedge clk);
    wr(TCC_OFF_FLAGS, 8'hFF);
    rd(TCC_OFF_FLAGS, 8'h00);
    lvl_b <= 1'b0;
    wait_irq(1'b0, n);
    `CHK(capture_irq, 1'b1)
    $display("test capture done");
    wr(TCC_OFF_CTRL_B, 8'hC0 | {5'h00, TCC_CS_D1024});
    lvl_a <= 1'b0;
    repeat (20) @(posedge clk);
    wr(TCC_OFF_FLAGS, 8'hFF);
    lvl_a <= 1'b1;
    repeat (3) @(posedge clk);
    lvl_a <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK(capture_irq, 1'b0)
    lvl_a <= 1'b1;
    wait_irq(1'b0, n_filt);
    `CHK(n_filt - n_plain, 4)
    $display("test filter done");
    wr(TCC_OFF_CTRL_B, 8'h00);
    wr(TCC_OFF_FLAGS, 8'hFF);
    wr(TCC_OFF_IRQ_EN, 8'h03 << TCC_B_CMP_F);
    wr(TCC_OFF_CNT_H, cmpv0[15:8]);
    wr(TCC_OFF_CNT_L, cmpv0[7:0]);
    wr(TCC_OFF_CTRL_B, {5'h00, TCC_CS_DIV1});
    wr(TCC_OFF_CTRL_B, 8'h00);
    `CHK(compare_irq_a, 1'b0)
    v = cmpv0 - 16'h0003;
    wr(TCC_OFF_CNT_H, v[15:8]);
    wr(TCC_OFF_CNT_L, v[7:0]);
    wr(TCC_OFF_CTRL_B, {5'h00, TCC_CS_DIV1});
    wait_irq(1'b1, n);
    wr(TCC_OFF_CTRL_B, 8'h00);
    `CHK(compare_irq_a, 1'b1)
    ack_a <= 1'b1;
    @(posedge clk);
    ack_a <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(compare_irq_a, 1'b0)
    $display("test compare done");
    for (int i = 0; i < 5; i++)
    begin
      wr(TCC_OFF_CTRL_A, {act_t[i], act_t[i], 4'h0});
      wr(TCC_OFF_CTRL_C, 8'hC0);
      @(posedge clk);
      `CHK(compare_output_a, out_t[i])
      `CHK(compare_output_b, out_t[i])
    end
    `CHK(compare_irq_a, 1'b0)
    `CHK(compare_irq_b, 1'b0)
    wr(TCC_OFF_CTRL_A, 8'h81);
    wr(TCC_OFF_CTRL_B, 8'h01 << TCC_B_WGM_HI);
    @(posedge clk);
    `CHK(compare_output_a, 1'b1)
    wr(TCC_OFF_CTRL_C, 8'hC0);
    @(posedge clk);
    `CHK(compare_output_a, 1'b1)
    wr(TCC_OFF_CMP_H[0], ~cmpv0[15:8]);
    wr(TCC_OFF_CMP_L[0], ~cmpv0[7:0]);
    rd(TCC_OFF_CMP_L[0], ~cmpv0[7:0]);
    wr(TCC_OFF_CTRL_A, 8'h80);
    wr(TCC_OFF_CTRL_B, 8'h00);
    rd(TCC_OFF_CMP_L[0], cmpv0[7:0]);
    $display("test force done");
    close_out();
  end
endmodule
